/* common/ers_map.svh */
// Constants of the edit ROM phrase sequencer
`ifndef ERS_MAP_SVH
`define ERS_MAP_SVH
`define ERS_CLK_PS 8000
`define ERS_UNIT_NS 16384000
`define ERS_UNIT_CYCLES (`ERS_UNIT_NS / (`ERS_CLK_PS / 1000))
`define ERS_ENTRY_BYTES 5'h10
`define ERS_LAST_INDEX 7'h7f
`define ERS_CMD_END 8'h00
`define ERS_SIL_LOW 7'h20
`define ERS_BEEP_TOP 4'hc
`define ERS_BIT_CH 7
`define ERS_BIT_SM 4
`define ERS_BEEP_RATE_SEL 3'h0
`define ERS_ATT_FLOOR 2'h3
`define ERS_RPT_ONCE 2'h0
`define ERS_RPT_TWICE 2'h1
`define ERS_RPT_FOUR 2'h2
`define ERS_RPT_ENDLESS 2'h3
`define ERS_PASSES_ONE 3'h1
`define ERS_PASSES_TWO 3'h2
`define ERS_PASSES_FOUR 3'h4
`define ERS_ROM_LAT 2'h2
`endif

/* common/ers_pkg.sv */
// Types of the edit ROM phrase sequencer
package ers_pkg;
    typedef enum logic [1:0] {
        ERS_OP_SPEECH,
        ERS_OP_SILENCE,
        ERS_OP_BEEP
    } ers_op_type;

    typedef struct packed {
        ers_op_type op;
        logic ch_one;
        logic smooth;
        logic [1:0] repeat_sel;
        logic [1:0] level;
        logic [1:0] freq;
        logic [6:0] arg;
    } ers_cmd_type;
endpackage

/* verilog/ers_skid.sv */
// Two-entry buffer between command decode and channel playback
`timescale 1ns/1ps
module ers_skid (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire ers_pkg::ers_cmd_type in_data,
    output logic out_valid,
    input wire logic out_ready,
    output ers_pkg::ers_cmd_type out_data
);
    ers_pkg::ers_cmd_type mem_reg [2];
    logic rd_reg;
    logic wr_reg;
    logic [1:0] cnt_reg;
    logic push;
    logic pop;

    assign in_ready = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || flush) begin
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            if (push) begin
                wr_reg <= ~wr_reg;
            end
            if (pop) begin
                rd_reg <= ~rd_reg;
            end
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

/* verilog/ers_tick.sv */
// Divider giving one pulse per 16.384 ms duration unit
`timescale 1ns/1ps
`include "ers_map.svh"
module ers_tick #(
    parameter int UNIT_CYCLES = `ERS_UNIT_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    output logic unit_tick
);
    logic [21:0] cnt_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_reg <= 22'h0;
            unit_tick <= 1'b0;
        end else if (cnt_reg == 22'(UNIT_CYCLES - 1)) begin
            cnt_reg <= 22'h0;
            unit_tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 22'h1;
            unit_tick <= 1'b0;
        end
    end
endmodule

/* verilog/ers_sequencer.sv */
// Edit ROM interpreter driving the two synthesis channels
`timescale 1ns/1ps
`include "ers_map.svh"
// How it works
// - Entry ends after sixteen bytes, eight pairs
// - Edit index ranges 1 to 127
// - Playback requests always go through edit table
// - Zero command byte ends the entry
// - Silence code, bit 7 picks channel
// - Silence lasts address value times 16.384 ms
// - Beep code 1100 plays on channel one
// - Beep level bits pick 1/8 to 1/2
// - Beep frequency bits pick 0.5 to 2 kHz
// - Beep lasts address value times 16.384 ms
// - Beep runs at fixed 8 kHz rate
// - Bits 6,5 set mean speech control
// - Repeat bits give one, two, four, endless
// - Smoothing halves volume per pass, floor 1/8
// - Volume bits give 0 to -18 dB
// - PCM phrases honour all speech fields
// - Melody forced onto channel one only
// - Queued entry starts after current ends
// - One pass: same waits, other starts together
// - Two passes: other starts at second pass
// - Four passes: other starts at fourth pass
// - Endless repeat discards following phrases
// - Mixed playback follows channel one rate
module ers_sequencer #(
    parameter int UNIT_CYCLES = `ERS_UNIT_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start_pulse,
    input wire logic [6:0] edit_index,
    input wire logic stop_pulse,
    output logic start_ready,
    output logic busy,
    output logic [10:0] rom_addr,
    input wire logic [7:0] rom_data,
    output logic [1:0] ch_start,
    output logic [6:0] ch1_phrase,
    output logic [6:0] ch2_phrase,
    output logic [1:0] ch1_atten,
    output logic [1:0] ch2_atten,
    output logic ch_beep,
    output logic [1:0] beep_level,
    output logic [1:0] beep_freq,
    output logic [1:0] ch_active,
    input wire logic [1:0] phrase_done,
    input wire logic ch1_is_melody,
    input wire logic [2:0] ch1_rate_sel,
    output logic [2:0] out_rate_sel
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH_CMD,
        ST_FETCH_ARG,
        ST_PUSH,
        ST_DRAIN
    } st_type;

    st_type st_reg;
    logic [6:0] entry_reg;
    logic [4:0] byte_reg;
    logic [1:0] lat_reg;
    logic [7:0] cmd_reg;
    logic [6:0] queued_reg;
    logic queued_valid_reg;
    logic discard_reg;
    logic unit_tick;
    ers_pkg::ers_cmd_type dec;
    logic dec_valid;
    logic dec_ready;
    ers_pkg::ers_cmd_type cur;
    logic cur_valid;
    logic cur_take;
    logic [1:0] ch_busy;

    ers_tick #(.UNIT_CYCLES(UNIT_CYCLES)) u_tick (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .unit_tick(unit_tick)
    );

    // Address built from edit index and byte count, no direct phrase path
    assign rom_addr = {entry_reg, byte_reg[3:0]};

    // Decode of the fetched byte pair
    always_comb begin
        dec = '0;
        dec.ch_one = cmd_reg[`ERS_BIT_CH];
        dec.arg = rom_data[6:0];
        if (cmd_reg[7:4] == `ERS_BEEP_TOP) begin
            dec.op = ers_pkg::ERS_OP_BEEP;
            dec.ch_one = 1'b1;
            dec.level = cmd_reg[3:2];
            dec.freq = cmd_reg[1:0];
        end else if (cmd_reg[6:0] == `ERS_SIL_LOW) begin
            dec.op = ers_pkg::ERS_OP_SILENCE;
        end else begin
            dec.op = ers_pkg::ERS_OP_SPEECH;
            dec.smooth = cmd_reg[`ERS_BIT_SM];
            dec.repeat_sel = cmd_reg[3:2];
            dec.level = cmd_reg[1:0];
        end
    end

    assign dec_valid = (st_reg == ST_PUSH) && !discard_reg;

    // Fetch walker: one command and one address byte per pair
    always_ff @(posedge core_clk) begin
        if (!rst_n || stop_pulse) begin
            st_reg <= ST_IDLE;
            byte_reg <= 5'h0;
            lat_reg <= 2'h0;
            cmd_reg <= 8'h0;
            entry_reg <= 7'h0;
            discard_reg <= 1'b0;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    if (queued_valid_reg && !busy) begin
                        entry_reg <= queued_reg;
                        byte_reg <= 5'h0;
                        lat_reg <= 2'h0;
                        discard_reg <= 1'b0;
                        st_reg <= ST_FETCH_CMD;
                    end
                end
                ST_FETCH_CMD: begin
                    if (lat_reg == `ERS_ROM_LAT) begin
                        lat_reg <= 2'h0;
                        if (rom_data == `ERS_CMD_END) begin
                            st_reg <= ST_DRAIN;
                        end else begin
                            cmd_reg <= rom_data;
                            byte_reg <= byte_reg + 5'h1;
                            st_reg <= ST_FETCH_ARG;
                        end
                    end else begin
                        lat_reg <= lat_reg + 2'h1;
                    end
                end
                ST_FETCH_ARG: begin
                    if (lat_reg == `ERS_ROM_LAT) begin
                        lat_reg <= 2'h0;
                        st_reg <= ST_PUSH;
                    end else begin
                        lat_reg <= lat_reg + 2'h1;
                    end
                end
                ST_PUSH: begin
                    if (discard_reg || dec_ready) begin
                        byte_reg <= byte_reg + 5'h1;
                        if (dec.op == ers_pkg::ERS_OP_SPEECH &&
                            dec.repeat_sel == `ERS_RPT_ENDLESS) begin
                            discard_reg <= 1'b1;
                        end
                        if (byte_reg + 5'h1 == `ERS_ENTRY_BYTES) begin
                            st_reg <= ST_DRAIN;
                        end else begin
                            st_reg <= ST_FETCH_CMD;
                        end
                    end
                end
                ST_DRAIN: begin
                    if (!cur_valid && ch_busy == 2'h0) begin
                        st_reg <= ST_IDLE;
                    end
                end
                default: begin
                    st_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // One pending request kept while an entry plays
    assign start_ready = !queued_valid_reg;
    always_ff @(posedge core_clk) begin
        if (!rst_n || stop_pulse) begin
            queued_valid_reg <= 1'b0;
            queued_reg <= 7'h0;
        end else if (start_pulse && !queued_valid_reg &&
                     edit_index != 7'h0) begin
            queued_valid_reg <= 1'b1;
            queued_reg <= edit_index;
        end else if (st_reg == ST_IDLE && queued_valid_reg && !busy) begin
            queued_valid_reg <= 1'b0;
        end
    end

    // Buffer lets decode run ahead without losing a command
    ers_skid u_skid (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .flush(stop_pulse),
        .in_valid(dec_valid),
        .in_ready(dec_ready),
        .in_data(dec),
        .out_valid(cur_valid),
        .out_ready(cur_take),
        .out_data(cur)
    );

    // Per channel playback: pass count, timer and volume
    logic [1:0] tgt;
    logic [2:0] pass_reg [2];
    logic [2:0] passes_reg [2];
    logic [6:0] units_reg [2];
    logic [1:0] timed_reg;
    logic [1:0] endless_reg;
    logic [1:0] smooth_reg;
    logic [1:0] att_reg [2];
    logic [1:0] last_pass;

    // Melody cannot leave channel one
    assign tgt = (cur.ch_one || ch1_is_melody) ? 2'b01 : 2'b10;

    // Same channel waits for end; other channel may go on last pass
    assign cur_take = cur_valid && ((ch_busy & tgt) == 2'h0) &&
        (ch_busy == 2'h0 || (last_pass & ~tgt) != 2'h0 ||
         (ch_busy & ~tgt) == 2'h0);

    function automatic logic [2:0] pass_total(input logic [1:0] sel);
        case (sel)
            `ERS_RPT_ONCE: pass_total = `ERS_PASSES_ONE;
            `ERS_RPT_TWICE: pass_total = `ERS_PASSES_TWO;
            `ERS_RPT_FOUR: pass_total = `ERS_PASSES_FOUR;
            default: pass_total = `ERS_PASSES_ONE;
        endcase
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            logic fin;
            assign ch_busy[gi] = ch_active[gi];
            assign last_pass[gi] = ch_active[gi] && !endless_reg[gi] &&
                !timed_reg[gi] && pass_reg[gi] == passes_reg[gi];
            assign fin = timed_reg[gi] ?
                (unit_tick && units_reg[gi] <= 7'h1) : phrase_done[gi];
            always_ff @(posedge core_clk) begin
                if (!rst_n || stop_pulse) begin
                    ch_active[gi] <= 1'b0;
                    ch_start[gi] <= 1'b0;
                    pass_reg[gi] <= 3'h0;
                    passes_reg[gi] <= 3'h0;
                    units_reg[gi] <= 7'h0;
                    timed_reg[gi] <= 1'b0;
                    endless_reg[gi] <= 1'b0;
                    smooth_reg[gi] <= 1'b0;
                    att_reg[gi] <= 2'h0;
                end else begin
                    ch_start[gi] <= 1'b0;
                    if (cur_take && tgt[gi]) begin
                        ch_active[gi] <= 1'b1;
                        pass_reg[gi] <= `ERS_PASSES_ONE;
                        passes_reg[gi] <= pass_total(cur.repeat_sel);
                        endless_reg[gi] <= cur.op == ers_pkg::ERS_OP_SPEECH &&
                            cur.repeat_sel == `ERS_RPT_ENDLESS;
                        timed_reg[gi] <= cur.op != ers_pkg::ERS_OP_SPEECH;
                        units_reg[gi] <= cur.arg;
                        smooth_reg[gi] <= cur.smooth &&
                            cur.repeat_sel != `ERS_RPT_ONCE;
                        att_reg[gi] <= cur.level;
                        ch_start[gi] <= cur.op == ers_pkg::ERS_OP_SPEECH;
                    end else if (ch_active[gi]) begin
                        if (timed_reg[gi] && unit_tick) begin
                            units_reg[gi] <= units_reg[gi] - 7'h1;
                        end
                        if (fin) begin
                            if (!timed_reg[gi] && (endless_reg[gi] ||
                                pass_reg[gi] != passes_reg[gi])) begin
                                pass_reg[gi] <= pass_reg[gi] + 3'h1;
                                ch_start[gi] <= 1'b1;
                                if (smooth_reg[gi] &&
                                    att_reg[gi] != `ERS_ATT_FLOOR) begin
                                    att_reg[gi] <= att_reg[gi] + 2'h1;
                                end
                            end else begin
                                ch_active[gi] <= 1'b0;
                            end
                        end
                    end
                end
            end
        end
    endgenerate

    // Playback outputs held in flip-flops
    always_ff @(posedge core_clk) begin
        if (!rst_n || stop_pulse) begin
            ch1_phrase <= 7'h0;
            ch2_phrase <= 7'h0;
            ch_beep <= 1'b0;
            beep_level <= 2'h0;
            beep_freq <= 2'h0;
        end else begin
            if (cur_take && tgt[0]) begin
                ch1_phrase <= cur.arg;
                ch_beep <= cur.op == ers_pkg::ERS_OP_BEEP;
                beep_level <= cur.level;
                beep_freq <= cur.freq;
            end else if (!ch_active[0]) begin
                ch_beep <= 1'b0;
            end
            if (cur_take && tgt[1]) begin
                ch2_phrase <= cur.arg;
            end
        end
    end

    assign ch1_atten = att_reg[0];
    assign ch2_atten = att_reg[1];
    assign busy = (st_reg != ST_IDLE) || (ch_active != 2'h0);

    // Beep fixes 8 kHz; otherwise channel one sets the pace
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            out_rate_sel <= `ERS_BEEP_RATE_SEL;
        end else if (ch_beep) begin
            out_rate_sel <= `ERS_BEEP_RATE_SEL;
        end else if (ch_active[0]) begin
            out_rate_sel <= ch1_rate_sel;
        end
    end

    property p_end_stops;
        @(posedge core_clk) disable iff (!rst_n)
        st_reg == ST_FETCH_CMD && lat_reg == `ERS_ROM_LAT &&
        rom_data == `ERS_CMD_END |=> st_reg == ST_DRAIN;
    endproperty
    a_end_stops: assert property (p_end_stops)
        else $error("end byte did not stop entry");
    property p_max_bytes;
        @(posedge core_clk) disable iff (!rst_n)
        byte_reg <= `ERS_ENTRY_BYTES;
    endproperty
    a_max_bytes: assert property (p_max_bytes)
        else $error("entry ran past sixteen bytes");
    property p_beep_ch1;
        @(posedge core_clk) disable iff (!rst_n)
        cur_take && cur.op == ers_pkg::ERS_OP_BEEP |-> tgt == 2'b01;
    endproperty
    a_beep_ch1: assert property (p_beep_ch1)
        else $error("beep not on channel one");
    property p_same_wait;
        @(posedge core_clk) disable iff (!rst_n)
        cur_take |-> (ch_busy & tgt) == 2'h0;
    endproperty
    a_same_wait: assert property (p_same_wait)
        else $error("same channel started early");
    property p_floor;
        @(posedge core_clk) disable iff (!rst_n)
        ch_active[0] && smooth_reg[0] && ch1_atten == 2'h3 |=>
        !ch_active[0] || ch1_atten == 2'h3;
    endproperty
    a_floor: assert property (p_floor)
        else $error("smoothing passed the floor");
    property p_rate;
        @(posedge core_clk) disable iff (!rst_n)
        ch_beep |=> out_rate_sel == `ERS_BEEP_RATE_SEL;
    endproperty
    a_rate: assert property (p_rate)
        else $error("beep not at 8 kHz");
    property p_index;
        @(posedge core_clk) disable iff (!rst_n)
        start_pulse && edit_index == 7'h0 && !queued_valid_reg |=>
        !queued_valid_reg;
    endproperty
    a_index: assert property (p_index)
        else $error("index zero accepted");
    property p_melody;
        @(posedge core_clk) disable iff (!rst_n)
        cur_take && ch1_is_melody |=> ch_active[0];
    endproperty
    a_melody: assert property (p_melody)
        else $error("melody left channel one");
endmodule

/* sim/ers_host_rom.sv */
// Stand-in for the edit ROM and the channel decoders facing the sequencer
`timescale 1ns/1ps
module ers_host_rom #(
    parameter int PASS_CYCLES = 30
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [10:0] rom_addr,
    output logic [7:0] rom_data,
    input wire logic [1:0] ch_start,
    output logic [1:0] phrase_done
);
    logic [7:0] mem [2048];
    logic [7:0] stage_reg;
    int left [2];

    // Unwritten entries read as end codes, never as unknowns
    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = 8'h00;
        end
    end

    // Two-cycle read path, so data lags the address as the sequencer expects
    always_ff @(posedge core_clk) begin
        stage_reg <= mem[rom_addr];
        rom_data <= stage_reg;
    end

    // Each pass lasts a fixed span and ends with one done pulse
    always_ff @(posedge core_clk) begin
        for (int c = 0; c < 2; c++) begin
            phrase_done[c] <= 1'b0;
            if (!rst_n) begin
                left[c] <= 0;
            end else if (ch_start[c]) begin
                left[c] <= PASS_CYCLES;
            end else if (left[c] == 1) begin
                left[c] <= 0;
                phrase_done[c] <= 1'b1;
            end else if (left[c] > 1) begin
                left[c] <= left[c] - 1;
            end
        end
    end
endmodule

/* sim/ers_testbench.sv */
// Self-checking bench for the edit ROM phrase sequencer
`timescale 1ns/1ps
`define CHK(what, expv, gotv) \
    begin \
        comparisons++; \
        if ((gotv) !== (expv)) begin \
            mismatches++; \
            $display("wrong value %s expected %0h seen %0h", what, \
                expv, gotv); \
        end \
    end
module testbench;
    localparam int UNIT = 20;
    logic core_clk, rst_n, start_pulse, stop_pulse, ch1_is_melody;
    logic start_ready, busy, ch_beep;
    logic [6:0] edit_index, ch1_phrase, ch2_phrase;
    logic [10:0] rom_addr;
    logic [7:0] rom_data;
    logic [1:0] ch_start, ch1_atten, ch2_atten, beep_level, beep_freq;
    logic [1:0] ch_active, phrase_done;
    logic [2:0] ch1_rate_sel, out_rate_sel, d1, r_seen;
    logic [11:0] q1 [$];
    logic [11:0] q2 [$];
    logic [11:0] e1 [$];
    logic [11:0] e2 [$];
    int mismatches = 0;
    int comparisons = 0;

    ers_sequencer #(.UNIT_CYCLES(UNIT)) i_ers_sequencer (
        .core_clk(core_clk), .rst_n(rst_n), .start_pulse(start_pulse),
        .edit_index(edit_index), .stop_pulse(stop_pulse),
        .start_ready(start_ready), .busy(busy), .rom_addr(rom_addr),
        .rom_data(rom_data), .ch_start(ch_start), .ch1_phrase(ch1_phrase),
        .ch2_phrase(ch2_phrase), .ch1_atten(ch1_atten),
        .ch2_atten(ch2_atten), .ch_beep(ch_beep), .beep_level(beep_level),
        .beep_freq(beep_freq), .ch_active(ch_active),
        .phrase_done(phrase_done), .ch1_is_melody(ch1_is_melody),
        .ch1_rate_sel(ch1_rate_sel), .out_rate_sel(out_rate_sel)
    );
    ers_host_rom #(.PASS_CYCLES(30)) i_ers_host_rom (
        .core_clk(core_clk), .rst_n(rst_n), .rom_addr(rom_addr),
        .rom_data(rom_data), .ch_start(ch_start), .phrase_done(phrase_done)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Pass log: phrase, attenuation and channel one passes finished so far
    always @(posedge core_clk) begin
        if (ch_start[0]) q1.push_back({ch1_phrase, ch1_atten, d1});
        if (ch_start[1]) q2.push_back({ch2_phrase, ch2_atten, d1});
        if (phrase_done[0]) d1 <= d1 + 3'h1;
        if (ch_active[0] && !ch_beep) r_seen <= out_rate_sel;
    end

    task automatic give_verdict();
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic ent(input logic [6:0] idx, input logic [15:0] p [$]);
        for (int i = 0; i < 16; i++) begin
            i_ers_host_rom.mem[{idx, 4'(i)}] = 8'h00;
        end
        foreach (p[i]) begin
            i_ers_host_rom.mem[{idx, 4'(2 * i)}] = p[i][15:8];
            i_ers_host_rom.mem[{idx, 4'(2 * i + 1)}] = p[i][7:0];
        end
        q1.delete();
        q2.delete();
        e1.delete();
        e2.delete();
        d1 = 3'h0;
    endtask

    task automatic go(input logic [6:0] idx);
        int n;
        n = 0;
        while (start_ready !== 1'b1 && n < 5000) begin
            @(negedge core_clk);
            n++;
        end
        start_pulse = 1'b1;
        edit_index = idx;
        @(negedge core_clk);
        start_pulse = 1'b0;
    endtask

    // Idle means nothing playing and no entry waiting its turn
    task automatic settle();
        int n;
        n = 0;
        repeat (4) @(negedge core_clk);
        while ((busy !== 1'b0 || start_ready !== 1'b1) && n < 5000) begin
            @(negedge core_clk);
            n++;
        end
        `CHK("idle reached", 1'b1, n < 5000)
    endtask

    task automatic judge(input string what);
        `CHK({what, " ch1 passes"}, e1.size(), q1.size())
        `CHK({what, " ch2 passes"}, e2.size(), q2.size())
        for (int i = 0; i < e1.size() && i < q1.size(); i++) begin
            `CHK({what, " ch1 pass"}, e1[i], q1[i])
        end
        for (int i = 0; i < e2.size() && i < q2.size(); i++) begin
            `CHK({what, " ch2 pass"}, e2[i], q2[i])
        end
    endtask

    task automatic t_index0();
        go(7'h00);
        repeat (5) @(negedge core_clk);
        `CHK("busy after index 0", 1'b0, busy)
    endtask

    task automatic t_passes();
        int n;
        for (int rp = 0; rp < 3; rp++) begin
            n = 1 << rp;
            ent(7'h7f, '{{8'hf1 | 8'(rp << 2), 8'h09}, 16'h620a});
            go(7'h7f);
            settle();
            for (int k = 0; k < n; k++) begin
                e1.push_back({7'h09, 2'(k > 1 ? 3 : k + 1), 3'(k)});
            end
            e2.push_back({7'h0a, 2'h2, 3'(n - 1)});
            // Pass one is the echo case: both commands repeat once
            judge("repeat");
            `CHK("repeat ch2 phrase", 7'h0a, ch2_phrase)
        end
    endtask

    task automatic t_sixteen();
        logic [15:0] p [$];
        for (int i = 0; i < 8; i++) begin
            p.push_back({8'he0 | 8'(i % 4), 8'(i + 1)});
        end
        ent(7'h05, p);
        go(7'h05);
        settle();
        for (int i = 0; i < 8; i++) begin
            e1.push_back({7'(i + 1), 2'(i % 4), 3'(i)});
        end
        judge("sixteen bytes");
        ent(7'h06, '{16'he103, 16'h0000, 16'he104});
        go(7'h06);
        settle();
        e1.push_back({7'h03, 2'h1, 3'h0});
        judge("end code");
    endtask

    task automatic t_endless();
        ent(7'h07, '{16'hec03, 16'h6004});
        go(7'h07);
        repeat (200) @(negedge core_clk);
        `CHK("endless busy", 1'b1, busy)
        `CHK("endless passes", 1'b1, q1.size() > 2)
        `CHK("discarded ch2", 0, q2.size())
        stop_pulse = 1'b1;
        @(negedge core_clk);
        stop_pulse = 1'b0;
        repeat (3) @(negedge core_clk);
        `CHK("busy after stop", 1'b0, busy)
        // Let the decoder stand-in finish its pass before the next scenario
        repeat (40) @(negedge core_clk);
    endtask

    task automatic t_melody_queue();
        ch1_is_melody = 1'b1;
        ent(7'h08, '{16'h6007});
        go(7'h08);
        settle();
        ch1_is_melody = 1'b0;
        e1.push_back({7'h07, 2'h0, 3'h0});
        judge("melody");
        `CHK("mixed rate", 3'h5, r_seen)
        ent(7'h02, '{16'he00c});
        ent(7'h01, '{16'he00b});
        go(7'h01);
        go(7'h02);
        settle();
        e1.push_back({7'h0b, 2'h0, 3'h0});
        e1.push_back({7'h0c, 2'h0, 3'h1});
        judge("queued entry");
    endtask

    // Beep and silence: fields while active and how long the channel stays on
    task automatic timed(input logic [7:0] c, input int arg, input int ch);
        int n;
        ent(7'h09, '{{c, 8'(arg)}});
        go(7'h09);
        n = 0;
        while (ch_active[ch] !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        `CHK("other channel idle", 1'b0, ch_active[1 - ch])
        if (c[7:4] == 4'hc) begin
            `CHK("beep flag", 1'b1, ch_beep)
            `CHK("beep level", c[3:2], beep_level)
            `CHK("beep freq", c[1:0], beep_freq)
            // Rate register follows the beep flag one cycle later
            @(negedge core_clk);
            `CHK("beep rate", 3'h0, out_rate_sel)
        end
        n = 0;
        while (ch_active[ch] === 1'b1 && n < 1000) begin
            @(negedge core_clk);
            n++;
        end
        `CHK("duration low", 1'b1, n >= (arg - 1) * UNIT)
        `CHK("duration high", 1'b1, n <= arg * UNIT + 10)
        settle();
    endtask

    initial begin
        rst_n = 1'b0;
        start_pulse = 1'b0;
        stop_pulse = 1'b0;
        ch1_is_melody = 1'b0;
        ch1_rate_sel = 3'h5;
        edit_index = 7'h00;
        d1 = 3'h0;
        r_seen = 3'h0;
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        `CHK("busy after reset", 1'b0, busy)
        `CHK("active after reset", 2'h0, ch_active)
        `CHK("rate after reset", 3'h0, out_rate_sel)
        t_index0();
        t_passes();
        t_sixteen();
        t_endless();
        t_melody_queue();
        for (int i = 0; i < 4; i++) begin
            timed({4'hc, 2'(i), 2'(3 - i)}, 2, 0);
        end
        timed(8'h20, 3, 1);
        timed(8'ha0, 1, 0);
        give_verdict();
    end

    // Whole run needs well under ten thousand cycles
    initial begin
        repeat (30000) @(posedge core_clk);
        mismatches++;
        give_verdict();
    end
endmodule
